// File: clock_synth_config_control.sv
module clock_synth_config_control
  import clock_synth_pkg::*;
#(
  parameter int LOCK_TIME_CYCLES = LOCK_CYCLES,
  parameter int ACQ_TIME_CYCLES = ACQ_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // device control pins
  input wire logic i_master_reset_n,
  input wire logic i_interface_source_pin,
  input wire logic i_ref_select,
  input wire logic i_bypass_n,
  input wire logic i_test_enable,
  input wire logic i_output_a_halt_n,
  input wire logic i_output_b_halt_n,
  input wire logic [1:0] i_addr_select,
  // parallel divider pins
  input wire div_cfg_t i_parallel_cfg,
  input wire logic i_parallel_pins_open,
  // serial side settings and load strobe
  input wire div_cfg_t i_serial_cfg,
  input wire logic i_serial_load,
  // reference clock levels
  input wire logic i_ext_ref_clk,
  input wire logic i_crystal_oscillator,
  // status and settings out
  output logic o_lock,
  output div_cfg_t o_active_cfg,
  output logic [6:0] o_i2c_slave_addr,
  output logic o_ref_is_crystal,
  output logic o_bypass_active,
  // clock outputs
  output logic o_clock_out_a,
  output logic o_clock_out_b
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (LOCK_TIME_CYCLES < 1 || LOCK_TIME_CYCLES > LOCK_MAX_CYCLES ||
      LOCK_TIME_CYCLES >= (1 << LOCK_CNT_W)) begin : g_bad_lock
    $error("lock time out of range");
  end
  if (ACQ_TIME_CYCLES < 1 || ACQ_TIME_CYCLES >= LOCK_TIME_CYCLES) begin : g_bad_acq
    $error("acquisition time out of range");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // distance between two feedback values
  function automatic logic [9:0] fb_step(input logic [9:0] a, input logic [9:0] b);
    fb_step = (a > b) ? (a - b) : (b - a);
  endfunction

  // postdivider code clamped to the legal range
  function automatic logic [2:0] clamp_code(input logic [2:0] code);
    clamp_code = (code > OUT_DIV_MAX_CODE) ? OUT_DIV_MAX_CODE : code;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  div_cfg_t cfg_r;               // settings feeding the synthesiser
  div_cfg_t cfg_nxt;             // settings selected this cycle
  div_cfg_t serial_r;            // serial-side settings store
  logic ref_sel_r;               // reference choice in use
  logic mr_n_r;                  // delayed reset pin for edge detect
  lock_state_t lock_state_r;     // lock tracker state
  logic [LOCK_CNT_W-1:0] lock_cnt_r;  // acquisition countdown
  logic [6:0] vco_cnt_r;         // free-running divider chain
  logic [2:0] code_a;            // effective postdivider code
  logic div_a;                   // divided channel a level
  logic div_b;                   // divided channel b level
  logic run_a_r;                 // channel a enabled
  logic run_b_r;                 // channel b enabled
  logic ref_level;               // selected reference level
  logic big_change;              // change needing a full relock
  logic small_change;            // small feedback step only

  // ----------------------------------------------------------------
  // settings source selection
  // ----------------------------------------------------------------
  // pins win when select is low; open pins fall back to defaults
  always_comb begin
    if (i_interface_source_pin) begin
      cfg_nxt = serial_r;
    end else if (i_parallel_pins_open) begin
      cfg_nxt = CFG_DEFAULT;
    end else begin
      cfg_nxt = i_parallel_cfg;
    end
  end

  // serial store: loads by strobe in serial mode, shadows pins otherwise
  // shadowing keeps the synthesiser steady when the select pin goes high
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      serial_r <= CFG_DEFAULT;
    end else if (!i_interface_source_pin) begin
      serial_r <= cfg_nxt;
    end else if (i_serial_load) begin
      serial_r <= i_serial_cfg;
    end
  end

  // settings in use, readable whatever the source
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cfg_r <= CFG_DEFAULT;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // reference selection: low picks the external clock input
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ref_sel_r <= 1'h1;
    end else begin
      ref_sel_r <= i_ref_select;
    end
  end

  // ----------------------------------------------------------------
  // lock tracking
  // ----------------------------------------------------------------
  // predivider, reference or a large feedback jump needs full lock time
  // the vco range itself is the partner's duty and is not checked here
  assign small_change = (cfg_nxt.fb_div != cfg_r.fb_div) &&
                        (fb_step(cfg_nxt.fb_div, cfg_r.fb_div) < FB_SMALL_STEP);
  assign big_change = (cfg_nxt.pre_div_sel != cfg_r.pre_div_sel) ||
                      (i_ref_select != ref_sel_r) ||
                      ((cfg_nxt.fb_div != cfg_r.fb_div) && !small_change);

  always_ff @(posedge i_core_clk) begin
    mr_n_r <= i_reset ? 1'h0 : i_master_reset_n;
  end

  // reset pulses are at least one cycle wide, so a level sample is enough
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      lock_state_r <= LK_HELD;
      lock_cnt_r <= '0;
    end else if (!i_master_reset_n) begin
      lock_state_r <= LK_HELD;
      lock_cnt_r <= '0;
    end else if (!mr_n_r || big_change) begin
      lock_state_r <= LK_ACQUIRE;
      lock_cnt_r <= LOCK_CNT_W'(LOCK_TIME_CYCLES - 1);
    end else if (small_change) begin
      lock_state_r <= LK_ACQUIRE;
      lock_cnt_r <= LOCK_CNT_W'(ACQ_TIME_CYCLES - 1);
    end else begin
      unique case (lock_state_r)
        LK_HELD: begin
          lock_state_r <= LK_HELD;  // wait for reset release
        end
        LK_ACQUIRE: begin
          if (lock_cnt_r == '0) begin
            lock_state_r <= LK_LOCKED;
          end else begin
            lock_cnt_r <= lock_cnt_r - 1'b1;
          end
        end
        LK_LOCKED: begin
          lock_state_r <= LK_LOCKED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output dividers
  // ----------------------------------------------------------------
  // core clock stands in for the vco; bit k divides by 2 << k
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      vco_cnt_r <= '0;
    end else begin
      vco_cnt_r <= vco_cnt_r + 1'b1;
    end
  end

  assign code_a = clamp_code(cfg_r.common_output_divider);
  assign div_a = vco_cnt_r[code_a];
  assign div_b = cfg_r.channel_b_extra_divider ? vco_cnt_r[code_a + 3'h1] : div_a;
  assign ref_level = ref_sel_r ? i_crystal_oscillator : i_ext_ref_clk;

  // halt takes effect only while the output is low, avoiding runt pulses
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      run_a_r <= 1'h0;
      run_b_r <= 1'h0;
    end else begin
      if (!o_clock_out_a) begin
        run_a_r <= i_output_a_halt_n;
      end
      if (!o_clock_out_b) begin
        run_b_r <= i_output_b_halt_n;
      end
    end
  end

  // bypass hands the reference straight through the output stage
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_clock_out_a <= 1'h0;
      o_clock_out_b <= 1'h0;
    end else if (!i_bypass_n) begin
      o_clock_out_a <= run_a_r & ref_level;
      o_clock_out_b <= run_b_r & ref_level;
    end else begin
      o_clock_out_a <= run_a_r & div_a;
      o_clock_out_b <= run_b_r & div_b;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_lock <= 1'h0;
      o_bypass_active <= 1'h0;
      o_i2c_slave_addr <= {I2C_ADDR_HIGH, 2'h0};
    end else begin
      o_lock <= (lock_state_r == LK_LOCKED) && i_master_reset_n && !big_change && !small_change;
      o_bypass_active <= !i_bypass_n;
      o_i2c_slave_addr <= {I2C_ADDR_HIGH, i_addr_select};
    end
  end

  // test enable is expected tied low; it has no effect in this logic
  assign o_active_cfg = cfg_r;
  assign o_ref_is_crystal = ref_sel_r;

endmodule

// File: clock_synth_pkg.sv
package clock_synth_pkg;

  // ----------------------------------------------------------------
  // divider settings carried as one unit
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] fb_div;                   // feedback divider value
    logic       pre_div_sel;              // predivider: 0 = /2, 1 = /4
    logic [2:0] common_output_divider;    // postdivider code for both channels
    logic       channel_b_extra_divider;  // 0 = /1, 1 = /2 on channel b
  } div_cfg_t;

  // ----------------------------------------------------------------
  // widths and defaults
  // ----------------------------------------------------------------
  localparam int FB_DIV_W = 10;
  localparam int OUT_DIV_W = 3;
  localparam logic [9:0] FB_DIV_DEFAULT = 10'h1F4;  // 01 1111 0100 b
  localparam logic PRE_DIV_DEFAULT = 1'h1;
  localparam logic [2:0] OUT_DIV_DEFAULT = 3'h2;
  localparam logic B_EXTRA_DEFAULT = 1'h0;
  localparam div_cfg_t CFG_DEFAULT = '{FB_DIV_DEFAULT, PRE_DIV_DEFAULT, OUT_DIV_DEFAULT, B_EXTRA_DEFAULT};

  // largest legal postdivider code (divide by 64); higher codes clamp
  localparam logic [2:0] OUT_DIV_MAX_CODE = 3'h5;
  // feedback step below which only a short acquisition is needed
  localparam logic [9:0] FB_SMALL_STEP = 10'h005;

  // ----------------------------------------------------------------
  // slave address: upper five bits fixed, low two from pins
  // ----------------------------------------------------------------
  localparam logic [4:0] I2C_ADDR_HIGH = 5'h0D;  // arbitrary value

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 10000;           // 10 MHz core clock
  localparam int LOCK_TIME_US = 3000;            // typical lock time
  localparam int LOCK_TIME_MAX_US = 6000;        // longest allowed lock time
  localparam int ACQ_TIME_US = 50;               // small-step acquisition
  localparam int LOCK_CYCLES = LOCK_TIME_US * CORE_CLK_KHZ / 1000;
  localparam int LOCK_MAX_CYCLES = LOCK_TIME_MAX_US * CORE_CLK_KHZ / 1000;
  localparam int ACQ_CYCLES = ACQ_TIME_US * CORE_CLK_KHZ / 1000;
  localparam int LOCK_CNT_W = 17;

  // ----------------------------------------------------------------
  // lock tracker states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LK_HELD,
    LK_ACQUIRE,
    LK_LOCKED
  } lock_state_t;

endpackage

// File: clock_synth_asserts.sv
module clock_synth_asserts
  import clock_synth_pkg::*;
#(
  parameter int LOCK_TIME_CYCLES = LOCK_CYCLES,
  parameter int ACQ_TIME_CYCLES = ACQ_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // watched inputs
  input wire logic i_master_reset_n,
  input wire logic i_interface_source_pin,
  input wire logic i_ref_select,
  input wire logic i_bypass_n,
  input wire logic i_output_a_halt_n,
  input wire logic [1:0] i_addr_select,
  input wire div_cfg_t i_parallel_cfg,
  input wire logic i_parallel_pins_open,
  input wire logic i_serial_load,
  // watched outputs
  input wire logic o_lock,
  input wire div_cfg_t o_active_cfg,
  input wire logic [6:0] o_i2c_slave_addr,
  input wire logic o_ref_is_crystal,
  input wire logic o_bypass_active,
  input wire logic o_clock_out_a
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // one domain, reset disables all
  // ----------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // past guards skip the reset edge
  a_addr_pins: assert property (
    !$past(i_reset) |-> o_i2c_slave_addr == {I2C_ADDR_HIGH, $past(i_addr_select)}) else $error("bad slave address");
  a_ref_copy: assert property (
    !$past(i_reset) |-> o_ref_is_crystal == $past(i_ref_select)) else $error("bad reference flag");
  a_bypass_copy: assert property (
    !$past(i_reset) |-> o_bypass_active == !$past(i_bypass_n)) else $error("bad bypass flag");
  a_lock_mr: assert property (
    !i_master_reset_n |=> !o_lock) else $error("lock high in master reset");
  a_lock_hold: assert property (
    $rose(i_master_reset_n) |=> !o_lock [*8]) else $error("lock too early");
  a_cfg_pins: assert property (
    !$past(i_reset) && !$past(i_interface_source_pin) |->
      o_active_cfg == ($past(i_parallel_pins_open) ? CFG_DEFAULT : $past(i_parallel_cfg)))
    else $error("settings do not follow pins");
  // serial mode: settings move only after a load
  a_cfg_hold: assert property (
    $past(i_interface_source_pin) && $past(i_interface_source_pin, 2) && !$past(i_serial_load, 2)
      && !$past(i_serial_load, 3) && !$past(i_reset) && !$past(i_reset, 2) |-> $stable(o_active_cfg))
    else $error("serial settings moved");
  a_halt_a: assert property (
    (i_bypass_n && !o_bypass_active && !i_output_a_halt_n && !o_clock_out_a) [*2] |=> !o_clock_out_a)
    else $error("halted output toggled");
  // any new feedback or predivider value shows with lock already low
  a_lock_change: assert property (
    $changed(o_active_cfg.fb_div) || $changed(o_active_cfg.pre_div_sel) |-> !o_lock)
    else $error("lock high after divider change");
endmodule
bind clock_synth_config_control clock_synth_asserts #(
  .LOCK_TIME_CYCLES(LOCK_TIME_CYCLES), .ACQ_TIME_CYCLES(ACQ_TIME_CYCLES)
) chk_u (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_master_reset_n(i_master_reset_n),
  .i_interface_source_pin(i_interface_source_pin), .i_ref_select(i_ref_select), .i_bypass_n(i_bypass_n),
  .i_output_a_halt_n(i_output_a_halt_n), .i_addr_select(i_addr_select), .i_parallel_cfg(i_parallel_cfg),
  .i_parallel_pins_open(i_parallel_pins_open), .i_serial_load(i_serial_load), .o_lock(o_lock),
  .o_active_cfg(o_active_cfg), .o_i2c_slave_addr(o_i2c_slave_addr), .o_ref_is_crystal(o_ref_is_crystal),
  .o_bypass_active(o_bypass_active), .o_clock_out_a(o_clock_out_a)
);

// File: board_ctrl_model.sv
module board_ctrl_model
  import clock_synth_pkg::*;
(
  // clock
  input wire logic i_core_clk,
  // configuration pins
  output logic o_master_reset_n,
  output logic o_sel,
  output logic o_open,
  output div_cfg_t o_pcfg,
  output div_cfg_t o_scfg,
  output logic o_load,
  output logic o_test_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle board: pins floating, parallel mode
  initial begin
    o_master_reset_n = 1'h1;
    o_sel = 1'h0;
    o_open = 1'h1;
    o_pcfg = CFG_DEFAULT;
    o_scfg = CFG_DEFAULT;
    o_load = 1'h0;
    o_test_enable = 1'h0;
  end
  // callers enter just after a rising edge; fb clipped to the vco window
  task automatic set_pins(input logic [9:0] fb, input logic [2:0] na, input logic nb, input logic pre,
                          input logic op);
    logic [9:0] lo;
    lo = pre ? 10'h154 : 10'h0AA;
    if (fb < lo) fb = lo;
    if (fb > (lo << 1)) fb = lo << 1;
    o_pcfg = '{fb, pre, na, nb};
    o_open = op;
  endtask
  // select is held for whole cycles by callers
  task automatic sel_src(input logic v);
    o_sel = v;
  endtask
  // one full cycle low, exactly the one-cycle minimum width
  task automatic pulse_mr();
    o_master_reset_n = 1'h0;
    @(posedge i_core_clk);
    #1 o_master_reset_n = 1'h1;
  endtask
  task automatic load_serial(input div_cfg_t c);
    o_scfg = c;
    o_load = 1'h1;
    @(posedge i_core_clk);
    #1 o_load = 1'h0;
  endtask
endmodule

// File: clock_synth_config_control_tb_top.sv
module clock_synth_config_control_tb_top
  import clock_synth_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // short lock counts keep the run brief
  localparam int LK = 40;
  localparam int AQ = 8;
  logic i_core_clk = 0;
  logic i_reset = 1;
  logic ref_sel = 1, byp_n = 1, ha_n = 1, hb_n = 1;
  logic [1:0] adr = 2'h0;
  logic mr_n, sel, opn, ld, ten, lock, refc, bypa, qa, qb;
  div_cfg_t pc, sc, acfg, c;
  logic [6:0] sadr;
  int error_cnt = 0, comparisons = 0, n, ra, rb;
  board_ctrl_model partner_u (.i_core_clk(i_core_clk), .o_master_reset_n(mr_n), .o_sel(sel), .o_open(opn),
    .o_pcfg(pc), .o_scfg(sc), .o_load(ld), .o_test_enable(ten));
  // reference levels tied apart so bypass shows which one is used
  clock_synth_config_control #(.LOCK_TIME_CYCLES(LK), .ACQ_TIME_CYCLES(AQ)) dut_u (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_master_reset_n(mr_n), .i_interface_source_pin(sel), .i_ref_select(ref_sel),
    .i_bypass_n(byp_n), .i_test_enable(ten), .i_output_a_halt_n(ha_n), .i_output_b_halt_n(hb_n),
    .i_addr_select(adr), .i_parallel_cfg(pc), .i_parallel_pins_open(opn), .i_serial_cfg(sc),
    .i_serial_load(ld), .i_ext_ref_clk(1'b0), .i_crystal_oscillator(1'b1), .o_lock(lock), .o_active_cfg(acfg),
    .o_i2c_slave_addr(sadr), .o_ref_is_crystal(refc), .o_bypass_active(bypa), .o_clock_out_a(qa),
    .o_clock_out_b(qb));
  initial begin
    forever #50 i_core_clk = !i_core_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k = 1);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask
  // bounded wait, n holds the edge count
  task automatic wait_lock();
    n = 0;
    while (lock !== 1'b1 && n < 2000) begin
      tick();
      n++;
    end
  endtask
  task automatic meas();
    logic pa, pb;
    ra = 0;
    rb = 0;
    pa = qa;
    pb = qb;
    repeat (256) begin
      tick();
      ra += (qa === 1'b1 && pa === 1'b0);
      rb += (qb === 1'b1 && pb === 1'b0);
      pa = qa;
      pb = qb;
    end
  endtask
  function automatic div_cfg_t exp_cfg(input logic op, input div_cfg_t p);
    return op ? CFG_DEFAULT : p;
  endfunction
  // rising edges in 256 cycles; codes above 5 clamp
  function automatic int exp_rises(input logic [2:0] code, input logic b);
    return 256 / ((2 << (code > 3'h5 ? 3'h5 : code)) << b);
  endfunction
  function automatic logic near(input int g, input int e, input int t);
    return g >= e - t && g <= e + t;
  endfunction
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(83));
    tick(16);
    i_reset = 0;
    wait_lock();
    chk("lock_time", 1, near(n, LK + 2, 4));
    chk("cfg_default", CFG_DEFAULT, acfg);
    repeat (12) begin
      partner_u.set_pins(10'($urandom), 3'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
      tick();
      chk("cfg_pins", exp_cfg(opn, pc), acfg);
    end
    // steps of 3 and 5 on the feedback divider
    partner_u.set_pins(10'h1F4, 3'h2, 1'h0, 1'h1, 1'h0);
    wait_lock();
    partner_u.set_pins(10'h1F7, 3'h2, 1'h0, 1'h1, 1'h0);
    tick();
    chk("lock_drop", 0, lock);
    wait_lock();
    chk("acq_time", 1, near(n, AQ + 1, 3));
    partner_u.set_pins(10'h1FC, 3'h2, 1'h0, 1'h1, 1'h0);
    tick();
    wait_lock();
    chk("relock_time", 1, near(n, LK + 1, 3));
    partner_u.pulse_mr();
    chk("lock_mr", 0, lock);
    wait_lock();
    chk("mr_lock_time", 1, near(n, LK + 1, 3));
    // serial load ignored in pin mode, then taken
    c = '{10'h200, 1'h1, 3'h3, 1'h1};
    partner_u.load_serial(c);
    chk("cfg_refuse", exp_cfg(opn, pc), acfg);
    partner_u.sel_src(1'h1);
    tick();
    chk("cfg_shadow", exp_cfg(opn, pc), acfg);
    partner_u.load_serial(c);
    partner_u.set_pins(10'h180, 3'h1, 1'h0, 1'h1, 1'h0);
    tick(2);
    chk("cfg_serial", c, acfg);
    partner_u.sel_src(1'h0);
    for (int k = 0; k < 16; k++) begin
      partner_u.set_pins(10'h1F4, k[2:0], k[3], 1'h1, 1'h0);
      tick(130);
      meas();
      chk("rise_a", 1, near(ra, exp_rises(k[2:0], 1'b0), 1));
      chk("rise_b", 1, near(rb, exp_rises(k[2:0], k[3]), 1));
    end
    for (int h = 0; h < 2; h++) begin
      ha_n = h[0];
      hb_n = !h[0];
      tick(140);
      meas();
      chk("halted", 0, h ? rb : ra);
      chk("running", 1, (h ? ra : rb) > 0);
    end
    ha_n = 1;
    hb_n = 1;
    for (int k = 0; k < 8; k++) begin
      adr = k[1:0];
      ref_sel = k[2];
      byp_n = 1'($urandom);
      tick(3);
      chk("slave_addr", {I2C_ADDR_HIGH, k[1:0]}, sadr);
      chk("ref_flag", k[2], refc);
      chk("bypass_flag", !byp_n, bypa);
      if (!byp_n) chk("bypass_out", k[2], qa);
      if (!byp_n) chk("bypass_out_b", k[2], qb);
    end
    results();
  end
  // watchdog about twice the expected run
  initial begin
    #1500000;
    error_cnt++;
    results();
  end
endmodule
